// >>> feps_core.v
`timescale 1ns/10ps
`include "feps_regs.vh"
module feps_core #(
    parameter [31:0] SMALL_REGION_ERASE_TIME = `FEPS_T_SE,
    parameter [31:0] MID_BLOCK_ERASE_TIME    = `FEPS_T_BE32,
    parameter [31:0] LARGE_BLOCK_ERASE_TIME  = `FEPS_T_BE64,
    parameter [31:0] FULL_ARRAY_ERASE_TIME   = `FEPS_T_CE,
    parameter [31:0] PAGE_PROGRAM_TIME       = `FEPS_T_PP,
    parameter [31:0] SUSPEND_CYC             = `FEPS_SUS_CYC
) (
    input  wire        clk_in,
    input  wire        rst_n_in,
    input  wire        cs_n_in,
    input  wire        sclk_in,
    input  wire [3:0]  io_in,
    input  wire        quad_lines_enable_in,
    input  wire        set_write_permit_in,
    input  wire        region_protected_in,
    input  wire        any_protected_in,
    output reg         busy_out,
    output reg         pause_status_bit_out,
    output reg         write_permit_latch_out,
    output reg         status_write_refused_out,
    output reg         erase_start_out,
    output reg  [2:0]  erase_kind_out,
    output reg  [23:0] erase_base_out,
    output reg         prog_wr_out,
    output reg  [23:0] prog_addr_out,
    output reg  [7:0]  prog_data_out,
    output reg         prog_start_out,
    output reg  [23:0] check_addr_out
);
    localparam [5:0] ST_IDLE = 6'h01;
    localparam [5:0] ST_PP   = 6'h02;
    localparam [5:0] ST_SE   = 6'h04;
    localparam [5:0] ST_B32  = 6'h08;
    localparam [5:0] ST_B64  = 6'h10;
    localparam [5:0] ST_CE   = 6'h20;
    // Resume latency in clock cycles
    localparam [31:0] RES_CYC = `FEPS_RES_CYC;

    reg [2:0]  cs_s_r;
    reg [2:0]  ck_s_r;
    reg [3:0]  io_a_r;
    reg [3:0]  io_b_r;
    reg [7:0]  op_r;
    reg [7:0]  sh_r;
    reg [3:0]  bitc_r;
    reg [5:0]  bytec_r;
    reg        quad_r;
    reg [23:0] addr_r;
    reg [7:0]  poff_r;
    reg [8:0]  pcnt_r;
    reg [5:0]  st_r;
    reg        paused_r;
    reg        resum_r;
    reg [31:0] slat_r;
    reg [7:0]  rlat_r;
    reg        tload_r;
    reg [31:0] tcnt_r;
    reg        cmd_ok_r;
    wire       tdone;
    wire       sclk_rise = ck_s_r[1] & ~ck_s_r[2];
    wire       cs_fall   = ~cs_s_r[1] & cs_s_r[2];
    wire       cs_rise   = cs_s_r[1] & ~cs_s_r[2];
    wire       cs_low    = ~cs_s_r[1];
    wire       running   = (st_r != ST_IDLE) && !paused_r && !resum_r;

    function is_erase;
        input [7:0] op;
        begin
            is_erase = op == `FEPS_OP_SE || op == `FEPS_OP_BE32 || op == `FEPS_OP_BE64 ||
                       op == `FEPS_OP_CE1 || op == `FEPS_OP_CE2 || op == `FEPS_OP_ERSR;
        end
    endfunction

    function is_prog;
        input [7:0] op;
        begin
            is_prog = op == `FEPS_OP_PP || op == `FEPS_OP_QPP || op == `FEPS_OP_PP42;
        end
    endfunction

    function [5:0] erase_state;
        input [7:0] op;
        begin
            case (op)
                `FEPS_OP_SE:   erase_state = ST_SE;
                `FEPS_OP_BE32: erase_state = ST_B32;
                `FEPS_OP_BE64: erase_state = ST_B64;
                default:       erase_state = ST_CE;
            endcase
        end
    endfunction

    // Erase state picked by the captured opcode
    wire [5:0] st_nxt = erase_state(op_r);

    feps_timer u_timer (
        .clk_in   (clk_in),
        .rst_n_in (rst_n_in),
        .load_in  (tload_r),
        .count_in (tcnt_r),
        .run_in   (running),
        .done_out (tdone)
    );

    // Pin synchronisers
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            cs_s_r <= 3'h7;
            ck_s_r <= 3'h0;
            io_a_r <= 4'h0;
            io_b_r <= 4'h0;
        end else begin
            cs_s_r <= {cs_s_r[1:0], cs_n_in};
            ck_s_r <= {ck_s_r[1:0], sclk_in};
            io_a_r <= io_in;
            io_b_r <= io_a_r;
        end
    end

    // Command shifter
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            op_r        <= 8'h0;
            sh_r        <= 8'h0;
            bitc_r      <= 4'h0;
            bytec_r     <= 6'h0;
            quad_r      <= 1'b0;
            addr_r      <= 24'h0;
            poff_r      <= 8'h0;
            pcnt_r      <= 9'h0;
            prog_wr_out <= 1'b0;
            prog_addr_out <= 24'h0;
            prog_data_out <= 8'h0;
            cmd_ok_r    <= 1'b0;
        end else begin
            prog_wr_out <= 1'b0;
            if (cs_fall) begin
                bitc_r  <= 4'h0;
                bytec_r <= 6'h0;
                quad_r  <= 1'b0;
                pcnt_r  <= 9'h0;
                cmd_ok_r <= 1'b0;
            end else if (cs_low && sclk_rise) begin
                if (quad_r) begin
                    sh_r   <= {sh_r[3:0], io_b_r};
                    bitc_r <= bitc_r + 4'h4;
                end else begin
                    sh_r   <= {sh_r[6:0], io_b_r[0]};
                    bitc_r <= bitc_r + 4'h1;
                end
                if ((quad_r && bitc_r == 4'h4) || (!quad_r && bitc_r == 4'h7)) begin
                    bitc_r   <= 4'h0;
                    cmd_ok_r <= 1'b1;
                    if (bytec_r != 6'h3F) begin
                        bytec_r <= bytec_r + 6'h1;
                    end
                    case (bytec_r)
                        6'h0: op_r <= quad_r ? {sh_r[3:0], io_b_r} : {sh_r[6:0], io_b_r[0]};
                        6'h1: addr_r[23:16] <= {sh_r[6:0], io_b_r[0]};
                        6'h2: addr_r[15:8]  <= {sh_r[6:0], io_b_r[0]};
                        6'h3: begin
                            addr_r[7:0] <= {sh_r[6:0], io_b_r[0]};
                            poff_r      <= {sh_r[6:0], io_b_r[0]};
                            quad_r      <= op_r == `FEPS_OP_QPP;
                        end
                        default: begin
                            if (op_r == `FEPS_OP_QPP && pcnt_r != 9'h100) begin
                                prog_wr_out   <= 1'b1;
                                prog_addr_out <= {addr_r[23:8], poff_r};
                                prog_data_out <= {sh_r[3:0], io_b_r};
                                pcnt_r        <= pcnt_r + 9'h1;
                            end
                            poff_r <= poff_r + 8'h1;
                        end
                    endcase
                end else begin
                    cmd_ok_r <= 1'b0;
                end
            end
        end
    end

    always @* begin
        check_addr_out = addr_r;
    end

    // Sequencer
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            st_r                     <= ST_IDLE;
            paused_r                 <= 1'b0;
            resum_r                  <= 1'b0;
            slat_r                   <= 32'h0;
            rlat_r                   <= 8'h0;
            busy_out                 <= 1'b0;
            pause_status_bit_out     <= 1'b0;
            write_permit_latch_out   <= 1'b0;
            status_write_refused_out <= 1'b0;
            erase_start_out          <= 1'b0;
            erase_kind_out           <= 3'h0;
            erase_base_out           <= 24'h0;
            prog_start_out           <= 1'b0;
            tload_r                  <= 1'b0;
            tcnt_r                   <= 32'h0;
        end else begin
            tload_r                  <= 1'b0;
            erase_start_out          <= 1'b0;
            prog_start_out           <= 1'b0;
            status_write_refused_out <= 1'b0;
            if (set_write_permit_in) begin
                write_permit_latch_out <= 1'b1;
            end
            if (slat_r != 32'h0) begin
                slat_r <= slat_r - 32'h1;
                if (slat_r == 32'h1) begin
                    busy_out <= 1'b0;
                end
            end
            if (resum_r) begin
                rlat_r <= rlat_r - 8'h1;
                if (rlat_r == 8'h1) begin
                    busy_out <= 1'b1;
                    resum_r  <= 1'b0;
                end
            end
            if (tdone) begin
                busy_out <= 1'b0;
                st_r     <= ST_IDLE;
                if (st_r != ST_PP) begin
                    write_permit_latch_out <= 1'b0;
                end
            end
            if (cs_rise && cmd_ok_r) begin
                if (op_r == `FEPS_OP_SUSP) begin
                    if (!pause_status_bit_out && busy_out && slat_r == 32'h0 &&
                        st_r != ST_IDLE && st_r != ST_CE) begin
                        paused_r             <= 1'b1;
                        pause_status_bit_out <= 1'b1;
                        slat_r               <= SUSPEND_CYC;
                    end
                end else if (op_r == `FEPS_OP_RESUME) begin
                    if (pause_status_bit_out && !busy_out) begin
                        paused_r             <= 1'b0;
                        pause_status_bit_out <= 1'b0;
                        resum_r              <= 1'b1;
                        rlat_r               <= RES_CYC[7:0];
                    end
                end else if (op_r == `FEPS_OP_WRSR && pause_status_bit_out) begin
                    status_write_refused_out <= 1'b1;
                end else if (is_erase(op_r) && op_r != `FEPS_OP_ERSR &&
                             st_r == ST_IDLE &&
                             !busy_out && !pause_status_bit_out &&
                             write_permit_latch_out) begin
                    if (((op_r == `FEPS_OP_CE1 || op_r == `FEPS_OP_CE2) && bytec_r == 6'h1 &&
                         !any_protected_in) ||
                        (op_r != `FEPS_OP_CE1 && op_r != `FEPS_OP_CE2 && bytec_r == 6'h4 &&
                         !region_protected_in)) begin
                        st_r            <= st_nxt;
                        busy_out        <= 1'b1;
                        erase_start_out <= 1'b1;
                        tload_r         <= 1'b1;
                        case (st_nxt)
                            ST_SE: begin
                                erase_kind_out <= 3'h1;
                                erase_base_out <= {addr_r[23:12], 12'h000};
                                tcnt_r         <= SMALL_REGION_ERASE_TIME;
                            end
                            ST_B32: begin
                                erase_kind_out <= 3'h2;
                                erase_base_out <= {addr_r[23:15], 15'h0000};
                                tcnt_r         <= MID_BLOCK_ERASE_TIME;
                            end
                            ST_B64: begin
                                erase_kind_out <= 3'h3;
                                erase_base_out <= {addr_r[23:16], 16'h0000};
                                tcnt_r         <= LARGE_BLOCK_ERASE_TIME;
                            end
                            default: begin
                                erase_kind_out <= 3'h4;
                                erase_base_out <= 24'h000000;
                                tcnt_r         <= FULL_ARRAY_ERASE_TIME;
                            end
                        endcase
                    end
                end else if (op_r == `FEPS_OP_QPP && !busy_out && !pause_status_bit_out &&
                             st_r == ST_IDLE &&
                             quad_lines_enable_in && write_permit_latch_out &&
                             bytec_r > 6'h4 && !region_protected_in) begin
                    st_r                   <= ST_PP;
                    busy_out               <= 1'b1;
                    prog_start_out         <= 1'b1;
                    tload_r                <= 1'b1;
                    tcnt_r                 <= PAGE_PROGRAM_TIME;
                    write_permit_latch_out <= 1'b0;
                end
            end
        end
    end
endmodule

// >>> feps_regs.vh
`ifndef FEPS_REGS_VH
`define FEPS_REGS_VH
`define FEPS_OP_QPP        8'h32
`define FEPS_OP_PP         8'h02
`define FEPS_OP_PP42       8'h42
`define FEPS_OP_SE         8'h20
`define FEPS_OP_BE32       8'h52
`define FEPS_OP_BE64       8'hD8
`define FEPS_OP_CE1        8'hC7
`define FEPS_OP_CE2        8'h60
`define FEPS_OP_ERSR       8'h44
`define FEPS_OP_WRSR       8'h01
`define FEPS_OP_SUSP       8'h75
`define FEPS_OP_RESUME     8'h7A
`define FEPS_PAGE_BYTES    256
`define FEPS_SUS_LAT_NS    20000
`define FEPS_RES_LAT_NS    200
`define FEPS_CLK_NS        10
`define FEPS_SUS_CYC       (`FEPS_SUS_LAT_NS / `FEPS_CLK_NS)
`define FEPS_RES_CYC       (`FEPS_RES_LAT_NS / `FEPS_CLK_NS)
`define FEPS_T_PP          32'h00001000
`define FEPS_T_SE          32'h00001000
`define FEPS_T_BE32        32'h00001000
`define FEPS_T_BE64        32'h00001000
`define FEPS_T_CE          32'h00001000
`endif

// >>> feps_timer.v
`timescale 1ns/10ps
`include "feps_regs.vh"
module feps_timer (
    input  wire        clk_in,
    input  wire        rst_n_in,
    input  wire        load_in,
    input  wire [31:0] count_in,
    input  wire        run_in,
    output reg         done_out
);
    reg [31:0] cnt_r;
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            cnt_r    <= 32'h0;
            done_out <= 1'b0;
        end else begin
            done_out <= 1'b0;
            if (load_in) begin
                cnt_r <= count_in;
            end else if (run_in && cnt_r != 32'h0) begin
                cnt_r <= cnt_r - 32'h1;
                if (cnt_r == 32'h1) begin
                    done_out <= 1'b1;
                end
            end
        end
    end
endmodule

// >>> feps_core_assertions.sv
`timescale 1ns/10ps
module feps_chk #(
    parameter [31:0] SUSPEND_CYC = 10
) (
    input wire        clk_in,
    input wire        rst_n_in,
    input wire        cs_n_in,
    input wire        quad_lines_enable_in,
    input wire        region_protected_in,
    input wire        any_protected_in,
    input wire        busy_out,
    input wire        pause_status_bit_out,
    input wire        write_permit_latch_out,
    input wire        status_write_refused_out,
    input wire        erase_start_out,
    input wire [2:0]  erase_kind_out,
    input wire [23:0] erase_base_out,
    input wire        prog_start_out
);
    localparam int SUS_WIN = SUSPEND_CYC + 2;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    rst_clears_a: assert property (disable iff (1'b0) !rst_n_in |=>
        !busy_out && !pause_status_bit_out && !write_permit_latch_out)
        else $error("state not cleared by reset");
    erase_wel_a: assert property (erase_start_out |-> write_permit_latch_out)
        else $error("erase started without write permit");
    erase_busy_a: assert property (erase_start_out |-> ##[0:1] busy_out)
        else $error("busy missing after erase start");
    erase_cs_a: assert property (erase_start_out |-> cs_n_in)
        else $error("erase started inside a frame");
    sector_align_a: assert property (erase_start_out && erase_kind_out == 3'd1
        |-> erase_base_out[11:0] == 12'h000) else $error("sector base not aligned");
    block_align_a: assert property (erase_start_out && erase_kind_out == 3'd3
        |-> erase_base_out[15:0] == 16'h0000) else $error("block base not aligned");
    region_lock_a: assert property (erase_start_out && erase_kind_out != 3'd4
        |-> !region_protected_in) else $error("protected region erased");
    chip_lock_a: assert property (erase_start_out && erase_kind_out == 3'd4
        |-> !any_protected_in) else $error("chip erase while protected");
    pause_busy_a: assert property ($rose(pause_status_bit_out) |-> $past(busy_out))
        else $error("pause set while idle");
    pause_idle_a: assert property ($rose(pause_status_bit_out) |-> ##[0:SUS_WIN] !busy_out)
        else $error("busy not cleared after suspend");
    resume_busy_a: assert property ($fell(pause_status_bit_out) |-> ##[0:21] busy_out)
        else $error("busy not restored after resume");
    wel_clear_a: assert property ($fell(busy_out) && !pause_status_bit_out
        |-> ##[0:1] !write_permit_latch_out) else $error("permit kept after cycle");
    refuse_pause_a: assert property (status_write_refused_out |-> pause_status_bit_out)
        else $error("status write refused while not paused");
    quad_en_a: assert property (prog_start_out |-> quad_lines_enable_in)
        else $error("program accepted without quad lines");
endmodule
bind feps_core feps_chk #(.SUSPEND_CYC(SUSPEND_CYC)) chk_u (.*);

// >>> feps_host.sv
`timescale 1ns/10ps
module feps_host (
    output logic       cs_n_out,
    output logic       sclk_out,
    output logic [3:0] io_out
);
    initial begin
        cs_n_out = 1'b1;
        sclk_out = 1'b0;
        io_out   = 4'hF;
    end
    // One link clock period: data set while low, taken on the rise
    task automatic tick(input logic [3:0] v);
        io_out = v;
        #62.5 sclk_out = 1'b1;
        #62.5 sclk_out = 1'b0;
    endtask
    // Opcode, address bytes, quad data bytes, then stray bits
    task automatic frame(input logic [7:0] op, input int na, input logic [23:0] a,
                         input int nd, input logic [7:0] d, input int extra);
        int i;
        logic [7:0] b;
        cs_n_out = 1'b0;
        #62.5;
        for (i = 7; i >= 0; i--) tick({~io_out[3:1], op[i]});
        for (i = na * 8 - 1; i >= 0; i--) tick({~io_out[3:1], a[i]});
        for (i = 0; i < nd; i++) begin
            b = d + i[7:0];
            tick(b[7:4]);
            tick(b[3:0]);
        end
        for (i = 0; i < extra; i++) tick(~io_out);
        #62.5 cs_n_out = 1'b1;
        io_out = ~io_out;
    endtask
endmodule

// >>> tb_top.sv
`timescale 1ns/10ps
module tb_top;
    logic        clk_in   = 1'b0;
    logic        rst_n_in = 1'b0;
    logic        qe       = 1'b0;
    logic        set_wp   = 1'b0;
    logic        rprot    = 1'b0;
    logic        aprot    = 1'b0;
    logic        cs_n, sclk, busy, pause, write_permit_latch, swr, es, pw, ps;
    logic [3:0]  io;
    logic [2:0]  kind, ek;
    logic [23:0] base, eb, paddr, caddr;
    logic [7:0]  pdata;
    logic [23:0] pw_a [$];
    logic [7:0]  pw_d [$];
    int          fails = 0, n_tests = 0, n_es = 0, n_ps = 0, n_sw = 0, t;
    logic [7:0]  ops [5]  = '{8'h20, 8'h52, 8'hD8, 8'hC7, 8'h60};
    logic [2:0]  kds [5]  = '{3'd1, 3'd2, 3'd3, 3'd4, 3'd4};
    logic [23:0] bss [3]  = '{24'h123000, 24'h120000, 24'h120000};
    always #5 clk_in = ~clk_in;
    feps_host host_u (.cs_n_out(cs_n), .sclk_out(sclk), .io_out(io));
    feps_core #(.SMALL_REGION_ERASE_TIME(2000), .MID_BLOCK_ERASE_TIME(50),
        .FULL_ARRAY_ERASE_TIME(400),
        .PAGE_PROGRAM_TIME(50), .SUSPEND_CYC(10)) dut_u (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .cs_n_in(cs_n), .sclk_in(sclk),
        .io_in(io), .quad_lines_enable_in(qe), .set_write_permit_in(set_wp),
        .region_protected_in(rprot), .any_protected_in(aprot), .busy_out(busy),
        .pause_status_bit_out(pause), .write_permit_latch_out(write_permit_latch),
        .status_write_refused_out(swr), .erase_start_out(es), .erase_kind_out(kind),
        .erase_base_out(base), .prog_wr_out(pw), .prog_addr_out(paddr),
        .prog_data_out(pdata), .prog_start_out(ps), .check_addr_out(caddr));
    // Capture the one-cycle pulses
    always @(posedge clk_in) begin
        if (es === 1'b1) begin
            n_es <= n_es + 1;
            ek   <= kind;
            eb   <= base;
        end
        if (ps === 1'b1) n_ps <= n_ps + 1;
        if (swr === 1'b1) n_sw <= n_sw + 1;
        if (pw === 1'b1) begin
            pw_a.push_back(paddr);
            pw_d.push_back(pdata);
        end
    end
    task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic clks(input int n);
        repeat (n) @(negedge clk_in);
    endtask
    task automatic permit;
        @(negedge clk_in) set_wp = 1'b1;
        @(negedge clk_in) set_wp = 1'b0;
        clks(2);
    endtask
    task automatic cmd(input logic [7:0] op, input int na, input logic [23:0] a, input int x);
        host_u.frame(op, na, a, 0, 8'h00, x);
        clks(8);
    endtask
    task automatic wait_idle;
        int k;
        for (k = 0; k < 5000 && busy !== 1'b0; k++) @(negedge clk_in);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        #400_000;
        fails++;
        tally_and_finish();
    end
    initial begin
        clks(12);
        rst_n_in = 1'b1;
        clks(4);
        cmp("reset state", 0, {busy, pause, write_permit_latch});
        cmd(8'h20, 3, 24'h123456, 0);
        cmp("erase without permit", 0, n_es);
        cmp("check address", 24'h123456, caddr);
        for (t = 0; t < 5; t++) begin
            permit();
            cmd(ops[t], (t < 3) ? 3 : 0, 24'h123456, 0);
            cmp("erase count", t + 1, n_es);
            cmp("erase kind", kds[t], ek);
            if (t < 3) cmp("erase base", bss[t], eb);
            cmp("busy in erase", 1, busy);
            wait_idle();
            cmp("busy and permit after erase", 0, {busy, write_permit_latch});
        end
        $display("test erase kinds done");
        permit();
        cmd(8'h20, 3, 24'h123456, 1);
        cmp("partial byte erase", 5, n_es);
        rprot = 1'b1;
        cmd(8'h20, 3, 24'h123456, 0);
        cmp("protected region erase", 5, n_es);
        rprot = 1'b0;
        aprot = 1'b1;
        cmd(8'hC7, 0, 24'h0, 0);
        cmp("protected chip erase", 5, n_es);
        aprot = 1'b0;
        $display("test refusals done");
        host_u.frame(8'h32, 3, 24'h0000FE, 3, 8'hA5, 0);
        clks(8);
        cmp("program without quad", 0, n_ps);
        pw_a.delete();
        pw_d.delete();
        qe = 1'b1;
        host_u.frame(8'h32, 3, 24'h0000FE, 3, 8'hA5, 0);
        clks(8);
        cmp("program start", 1, n_ps);
        cmp("program bytes", 3, pw_a.size());
        for (t = 0; t < 3 && t < pw_a.size(); t++) begin
            cmp("program addr", (24'h0000FE + t) & 24'h0000FF, pw_a[t]);
            cmp("program data", 8'hA5 + t, pw_d[t]);
        end
        wait_idle();
        $display("test quad program done");
        cmd(8'h75, 0, 24'h0, 0);
        cmp("suspend when idle", 0, pause);
        permit();
        cmd(8'h20, 3, 24'h004000, 0);
        cmd(8'h75, 0, 24'h0, 0);
        clks(12);
        cmp("suspended state", 1, {busy, pause});
        permit();
        cmd(8'h20, 3, 24'h008000, 0);
        cmp("erase in suspend", 6, n_es);
        cmd(8'h01, 1, 24'h000002, 0);
        cmp("status write refused", 1, n_sw);
        cmd(8'h7A, 0, 24'h0, 0);
        clks(21);
        cmp("resumed state", 2, {busy, pause});
        wait_idle();
        cmp("permit after resumed erase", 0, write_permit_latch);
        $display("test suspend resume done");
        permit();
        cmd(8'hC7, 0, 24'h0, 0);
        cmd(8'h75, 0, 24'h0, 0);
        cmp("suspend in chip erase", 2, {busy, pause});
        wait_idle();
        permit();
        cmd(8'h20, 3, 24'h004000, 0);
        cmd(8'h75, 0, 24'h0, 0);
        clks(12);
        rst_n_in = 1'b0;
        clks(3);
        rst_n_in = 1'b1;
        clks(4);
        cmp("reset in suspend", 0, {busy, pause, write_permit_latch});
        $display("test chip erase and reset done");
        tally_and_finish();
    end
endmodule
